// >>> rtl/memory_map_bus_access.sv
// How it works
// - read-only 8-bit identity code, writes ignored
// - every bus cycle takes one clock
// - split access by device and access width
// - 32-bit moves zero or drop top byte
// - stack moves keep full 32-bit word
// - peripherals take 8/16/32-bit accesses
// - no fetch overlap on same memory
// - fetch stalls for data cycle count
// - last four flash bytes are protect words
// - 4K peripheral area 2 at 0x5000
// - 1K peripheral area 1 at 0x4000
// - top 1K is core I/O area
// - last 64 RAM bytes are debug RAM
`timescale 1ns/100ps
`default_nettype none
`include "memory_map_bus_access_defines.svh"

module memory_map_bus_access #(
  parameter int ADDR_W = 24,
  // arbitrary neutral identity value
  parameter logic [7:0] ID_CODE = 8'h5A
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dataValid,
  input wire logic [ADDR_W-1:0] dataAddr,
  input wire logic [1:0] dataSize,
  input wire logic dataWrite,
  input wire logic [31:0] dataWdata,
  input wire logic dataStack,
  output logic dataAccept,
  output logic dataDone,
  output logic [31:0] dataRdata,
  input wire logic fetchValid,
  input wire logic [ADDR_W-1:0] fetchAddr,
  output logic fetchReady,
  output logic fetchDone,
  output logic [15:0] fetchRdata,
  output logic dbValid,
  output logic [2:0] dbRegion,
  output logic [ADDR_W-1:0] dbAddr,
  output logic dbWrite,
  output logic [1:0] dbWidth,
  output logic [31:0] dbWdata,
  input wire logic [31:0] dbRdata,
  output logic fbValid,
  output logic [2:0] fbRegion,
  output logic [ADDR_W-1:0] fbAddr,
  input wire logic [15:0] fbRdata
);

  // the decode tables assume a 24-bit space, so any other width is refused
  if (ADDR_W != 24) begin : gBadWidth
    $error("address map needs ADDR_W of 24");
  end

  ////////////////////////////////////////////////////////////////////
  // address decode

  function automatic memory_map_bus_access_pkg::region_e decode(
    input logic [23:0] a);
    if (a <= `RAM_LAST) begin
      decode = (a >= `DBG_FIRST) ? memory_map_bus_access_pkg::REG_DBG :
               memory_map_bus_access_pkg::REG_RAM;
    end else if (a >= `P1_FIRST && a <= `P1_LAST) begin
      decode = memory_map_bus_access_pkg::REG_P1;
    end else if (a >= `P2_FIRST && a <= `P2_LAST) begin
      decode = memory_map_bus_access_pkg::REG_P2;
    end else if (a >= `FL_FIRST && a <= `FL_LAST) begin
      decode = (a >= `FLP_FIRST) ? memory_map_bus_access_pkg::REG_FLPROT :
               memory_map_bus_access_pkg::REG_FLASH;
    end else if (a >= `CIO_FIRST) begin
      decode = memory_map_bus_access_pkg::REG_CIO;
    end else begin
      decode = memory_map_bus_access_pkg::REG_NONE;
    end
  endfunction

  // peripheral sub-ranges pick their own width
  function automatic memory_map_bus_access_pkg::width_e widthOf(
    input memory_map_bus_access_pkg::region_e r, input logic [23:0] a);
    case (r)
      memory_map_bus_access_pkg::REG_FLASH,
      memory_map_bus_access_pkg::REG_FLPROT: widthOf = memory_map_bus_access_pkg::W16;
      memory_map_bus_access_pkg::REG_P1: begin
        widthOf = (a <= `P1_BYTE_LAST) ? memory_map_bus_access_pkg::W8 :
                  memory_map_bus_access_pkg::W16;
      end
      memory_map_bus_access_pkg::REG_P2: begin
        widthOf = (a <= `P2_BYTE_LAST) ? memory_map_bus_access_pkg::W8 :
                  memory_map_bus_access_pkg::W16;
      end
      default: widthOf = memory_map_bus_access_pkg::W32;
    endcase
  endfunction

  function automatic logic [2:0] cyclesOf(input logic [1:0] w, input logic [1:0] s);
    cyclesOf = 3'h1;
    if (w == memory_map_bus_access_pkg::W8) begin
      if (s == memory_map_bus_access_pkg::SZ16) cyclesOf = 3'h2;
      if (s == memory_map_bus_access_pkg::SZ32) cyclesOf = 3'h4;
    end else if (w == memory_map_bus_access_pkg::W16) begin
      if (s == memory_map_bus_access_pkg::SZ32) cyclesOf = 3'h2;
    end
  endfunction

  // flash and RAM are the only memories shared with fetch
  function automatic logic [1:0] memClass(input logic [2:0] r);
    case (r)
      memory_map_bus_access_pkg::REG_FLASH,
      memory_map_bus_access_pkg::REG_FLPROT: memClass = 2'h1;
      memory_map_bus_access_pkg::REG_RAM,
      memory_map_bus_access_pkg::REG_DBG: memClass = 2'h2;
      default: memClass = 2'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // data access sequencer

  memory_map_bus_access_pkg::state_e state_r, state_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [1:0] size_r, size_nxt, width_r, width_nxt;
  logic write_r, write_nxt, stack_r, stack_nxt, ext_r, ext_nxt;
  logic [31:0] wdata_r, wdata_nxt, acc_r, acc_nxt;
  logic [2:0] region_r, region_nxt, total_r, total_nxt, idx_r, idx_nxt;
  logic dataDone_r, dataDone_nxt;
  logic [31:0] dataRdata_r, dataRdata_nxt;
  logic ctrl_r, ctrl_nxt;
  memory_map_bus_access_pkg::region_e inRegion;
  memory_map_bus_access_pkg::width_e inWidth;
  logic [4:0] laneShift;
  logic [31:0] laneMask, sizeMask, outWord, wordOut;
  logic last, take, blocked;

  assign inRegion = decode(dataAddr);
  assign inWidth = widthOf(inRegion, dataAddr);
  assign take = dataValid && dataAccept;
  // debug RAM can be fenced off from application accesses
  assign blocked = ctrl_r && (inRegion == memory_map_bus_access_pkg::REG_DBG);
  assign dataAccept = (state_r == memory_map_bus_access_pkg::S_IDLE);
  assign last = (idx_r == total_r - 3'h1);
  // byte offset of this cycle times eight
  assign laneShift = {idx_r[1:0] << width_r, 3'h0};
  assign laneMask = (width_r == memory_map_bus_access_pkg::W8) ? 32'h000000FF :
                    (width_r == memory_map_bus_access_pkg::W16) ? 32'h0000FFFF : 32'hFFFFFFFF;
  assign sizeMask = (size_r == memory_map_bus_access_pkg::SZ8) ? 32'h000000FF :
                    (size_r == memory_map_bus_access_pkg::SZ16) ? 32'h0000FFFF : 32'hFFFFFFFF;
  assign outWord = stack_r ? wdata_r : {8'h00, wdata_r[`HI_LSB-1:0]};

  assign dbValid = (state_r == memory_map_bus_access_pkg::S_RUN) && ext_r;
  assign dbRegion = region_r;
  assign dbAddr = addr_r + {22'h0, idx_r[1:0] << width_r};
  assign dbWrite = write_r;
  assign dbWidth = width_r;
  assign dbWdata = (outWord >> laneShift) & laneMask;

  // next state of the sequencer; reads are assembled low lane first
  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    size_nxt = size_r;
    width_nxt = width_r;
    write_nxt = write_r;
    stack_nxt = stack_r;
    ext_nxt = ext_r;
    wdata_nxt = wdata_r;
    region_nxt = region_r;
    total_nxt = total_r;
    idx_nxt = idx_r;
    acc_nxt = acc_r;
    dataDone_nxt = 1'b0;
    dataRdata_nxt = dataRdata_r;
    wordOut = acc_r;
    case (state_r)
      memory_map_bus_access_pkg::S_IDLE: begin
        if (take) begin
          state_nxt = memory_map_bus_access_pkg::S_RUN;
          addr_nxt = dataAddr;
          size_nxt = dataSize;
          width_nxt = inWidth;
          write_nxt = dataWrite;
          stack_nxt = dataStack;
          wdata_nxt = dataWdata;
          region_nxt = inRegion;
          ext_nxt = !blocked && (inRegion != memory_map_bus_access_pkg::REG_NONE) &&
                    (inRegion != memory_map_bus_access_pkg::REG_CIO);
          total_nxt = ext_nxt ? cyclesOf(inWidth, dataSize) : 3'h1;
          idx_nxt = 3'h0;
          acc_nxt = 32'h0;
        end
      end
      memory_map_bus_access_pkg::S_RUN: begin
        if (ext_r && !write_r) begin
          wordOut = acc_r | ((dbRdata & laneMask) << laneShift);
        end else if (!ext_r && !write_r &&
                     region_r == memory_map_bus_access_pkg::REG_CIO &&
                     addr_r == `ID_ADDR) begin
          wordOut = {24'h0, ID_CODE};
        end
        acc_nxt = wordOut;
        idx_nxt = idx_r + 3'h1;
        if (last) begin
          state_nxt = memory_map_bus_access_pkg::S_IDLE;
          dataDone_nxt = 1'b1;
          dataRdata_nxt = wordOut & sizeMask &
                          (stack_r ? 32'hFFFFFFFF : 32'h00FFFFFF);
        end
      end
      default: state_nxt = memory_map_bus_access_pkg::S_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= memory_map_bus_access_pkg::S_IDLE;
      addr_r <= 24'h0;
      size_r <= 2'h0;
      width_r <= 2'h0;
      write_r <= 1'b0;
      stack_r <= 1'b0;
      ext_r <= 1'b0;
      wdata_r <= 32'h0;
      region_r <= 3'h0;
      total_r <= 3'h1;
      idx_r <= 3'h0;
      acc_r <= 32'h0;
      dataDone_r <= 1'b0;
      dataRdata_r <= 32'h0;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      size_r <= size_nxt;
      width_r <= width_nxt;
      write_r <= write_nxt;
      stack_r <= stack_nxt;
      ext_r <= ext_nxt;
      wdata_r <= wdata_nxt;
      region_r <= region_nxt;
      total_r <= total_nxt;
      idx_r <= idx_nxt;
      acc_r <= acc_nxt;
      dataDone_r <= dataDone_nxt;
      dataRdata_r <= dataRdata_nxt;
    end
  end

  assign dataDone = dataDone_r;
  assign dataRdata = dataRdata_r;

  ////////////////////////////////////////////////////////////////////
  // instruction fetch path

  logic conflict, fetchDone_r, fetchDone_nxt;
  logic [15:0] fetchRdata_r, fetchRdata_nxt, stalls_r, stalls_nxt;
  logic [2:0] stallCnt_r, stallCnt_nxt;

  assign fbRegion = decode(fetchAddr);
  assign fbAddr = fetchAddr;
  assign conflict = dbValid && (memClass(region_r) != 2'h0) &&
                    (memClass(region_r) == memClass(fbRegion));
  assign fbValid = fetchValid && !conflict;
  assign fetchReady = fbValid;

  // fetch capture and a stall counter that status shows
  always_comb begin
    fetchDone_nxt = fbValid;
    fetchRdata_nxt = fbValid ? fbRdata : fetchRdata_r;
    stalls_nxt = stalls_r + {15'h0, fetchValid && conflict};
    stallCnt_nxt = conflict ? stallCnt_r + 3'h1 : 3'h0;
  end

  // fetch registers; stall count wraps
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      fetchDone_r <= 1'b0;
      fetchRdata_r <= 16'h0;
      stalls_r <= 16'h0;
      stallCnt_r <= 3'h0;
    end else begin
      fetchDone_r <= fetchDone_nxt;
      fetchRdata_r <= fetchRdata_nxt;
      stalls_r <= stalls_nxt;
      stallCnt_r <= stallCnt_nxt;
    end
  end

  assign fetchDone = fetchDone_r;
  assign fetchRdata = fetchRdata_r;

  ////////////////////////////////////////////////////////////////////
  // APB slave: identity, control, status

  logic [31:0] prdata_r, prdata_nxt, readVal;
  logic hit, setup, access;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign hit = (paddr == `ID_ADDR) || (paddr == `CTRL_ADDR) || (paddr == `STAT_ADDR);
  // zero-wait slave, so read data is latched in setup
  assign pready = 1'b1;
  assign pslverr = access && !hit;

  // read mux and control write
  always_comb begin
    readVal = 32'h0;
    if (paddr == `ID_ADDR) readVal = {24'h0, ID_CODE};
    if (paddr == `CTRL_ADDR) readVal[`CTRL_GUARD] = ctrl_r;
    if (paddr == `STAT_ADDR) begin
      readVal[`STAT_BUSY] = (state_r == memory_map_bus_access_pkg::S_RUN);
      readVal[`STAT_REG_MSB:`STAT_REG_LSB] = region_r;
      readVal[31:`STAT_CNT_LSB] = stalls_r;
    end
    prdata_nxt = (setup && !pwrite) ? readVal : prdata_r;
    ctrl_nxt = (access && pwrite && paddr == `CTRL_ADDR) ? pwdata[`CTRL_GUARD] : ctrl_r;
  end

  // bus registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prdata_r <= 32'h0;
      ctrl_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  assign prdata = prdata_r;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_id_read;
    setup && !pwrite && paddr == `ID_ADDR |=> prdata == {24'h0, ID_CODE};
  endproperty
  a_id_read: assert property (p_id_read) else $error("identity read wrong");

  property p_single;
    take && dataSize == memory_map_bus_access_pkg::SZ8 |=> !dataDone ##1 dataDone;
  endproperty
  a_single: assert property (p_single) else $error("byte access not two clocks");

  property p_split4;
    take && !blocked && inWidth == memory_map_bus_access_pkg::W8 &&
    dataSize == memory_map_bus_access_pkg::SZ32 && inRegion != 3'h0
    |=> dbValid [*4] ##1 (dataDone && !dbValid);
  endproperty
  a_split4: assert property (p_split4) else $error("byte device split wrong");

  property p_hi_zero;
    dataDone && !stack_r |-> dataRdata[31:`HI_LSB] == 8'h00;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("read top byte kept");

  property p_stack;
    dbValid && write_r && stack_r && width_r == memory_map_bus_access_pkg::W32
    |-> dbWdata == wdata_r;
  endproperty
  a_stack: assert property (p_stack) else $error("stack word altered");

  property p_split2;
    take && inWidth == memory_map_bus_access_pkg::W16 &&
    dataSize == memory_map_bus_access_pkg::SZ32 && inRegion == 3'h4
    |=> dbValid ##1 (dbValid && dbAddr == $past(dbAddr) + 24'h2) ##1 dataDone;
  endproperty
  a_split2: assert property (p_split2) else $error("halfword split wrong");

  property p_no_overlap;
    fbValid && dbValid |-> memClass(region_r) != memClass(fbRegion) ||
                           memClass(region_r) == 2'h0;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("fetch overlapped data");

  property p_stretch;
    $fell(conflict) |-> stallCnt_r == total_r;
  endproperty
  a_stretch: assert property (p_stretch) else $error("fetch stall length wrong");

  property p_protect;
    dbValid && dbAddr >= `FLP_FIRST && dbAddr <= `FL_LAST |-> dbRegion == 3'h6;
  endproperty
  a_protect: assert property (p_protect) else $error("protect words misdecoded");

  property p_reserved;
    take && inRegion == 3'h0 |=> !dbValid ##1 (dataDone && dataRdata == 32'h0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved access misbehaved");

endmodule

`default_nettype wire

// >>> rtl/memory_map_bus_access_defines.svh
`ifndef MEMORY_MAP_BUS_ACCESS_DEFINES_SVH
`define MEMORY_MAP_BUS_ACCESS_DEFINES_SVH

// address map of the 24-bit space
`define RAM_LAST 24'h0007FF
`define DBG_FIRST 24'h0007C0
`define P1_FIRST 24'h004000
`define P1_LAST 24'h0043FF
`define P1_BYTE_LAST 24'h00411F
`define P2_FIRST 24'h005000
`define P2_LAST 24'h005FFF
`define P2_BYTE_LAST 24'h0052BF
`define FL_FIRST 24'h008000
`define FL_LAST 24'h00FFFF
`define FLP_FIRST 24'h00FFFC
`define CIO_FIRST 24'hFFFC00

// register byte addresses
`define ID_ADDR 24'hFFFF84
`define CTRL_ADDR 24'hFFFF88
`define STAT_ADDR 24'hFFFF8C

// field positions
`define CTRL_GUARD 0
`define STAT_BUSY 0
`define STAT_REG_LSB 1
`define STAT_REG_MSB 3
`define STAT_CNT_LSB 16
`define HI_LSB 24

`endif

// >>> rtl/memory_map_bus_access_pkg.sv
package memory_map_bus_access_pkg;

  typedef enum logic [2:0] {
    REG_NONE = 3'h0,
    REG_RAM = 3'h1,
    REG_DBG = 3'h2,
    REG_P1 = 3'h3,
    REG_P2 = 3'h4,
    REG_FLASH = 3'h5,
    REG_FLPROT = 3'h6,
    REG_CIO = 3'h7
  } region_e;

  typedef enum logic [1:0] {SZ8 = 2'h0, SZ16 = 2'h1, SZ32 = 2'h2} size_e;

  typedef enum logic [1:0] {W8 = 2'h0, W16 = 2'h1, W32 = 2'h2} width_e;

  typedef enum logic {S_IDLE = 1'b0, S_RUN = 1'b1} state_e;

endpackage

// >>> sim/mem_side_model.sv
`timescale 1ns/100ps
`default_nettype none

module mem_side_model (
  input wire logic clock,
  input wire logic dbValid,
  input wire logic dbWrite,
  input wire logic [23:0] dbAddr,
  output logic [31:0] dbRdata,
  input wire logic fbValid,
  input wire logic [23:0] fbAddr,
  output logic [15:0] fbRdata
);
  logic [31:0] lastD = 32'h0;
  logic [15:0] lastF = 16'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // same cycle answer
  // an idle bus shows the inverse of the last word, so stale data never matches
  always_comb begin
    dbRdata = ~lastD;
    if (dbValid && !dbWrite) begin
      dbRdata = {8'hC3, dbAddr};
    end
    fbRdata = fbValid ? (fbAddr[15:0] ^ 16'h5555) : ~lastF;
  end

  // remember what was last driven on each bus
  always_ff @(posedge clock) begin
    lastD <= dbRdata;
    lastF <= fbRdata;
  end
endmodule

`default_nettype wire

// >>> sim/tb_memory_map_bus_access.sv
`timescale 1ns/100ps
`default_nettype none
`include "memory_map_bus_access_defines.svh"

module tb_memory_map_bus_access;
  localparam logic [7:0] ID = 8'h3C; // arbitrary identity value
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [23:0] paddr = 24'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic dataValid = 1'b0;
  logic [23:0] dataAddr = 24'h0;
  logic [1:0] dataSize = 2'h0;
  logic dataWrite = 1'b0;
  logic [31:0] dataWdata = 32'h0;
  logic dataStack = 1'b0;
  logic dataAccept;
  logic dataDone;
  logic [31:0] dataRdata;
  logic fetchValid = 1'b0;
  logic [23:0] fetchAddr = 24'h0;
  logic fetchReady;
  logic fetchDone;
  logic [15:0] fetchRdata;
  logic dbValid;
  logic [2:0] dbRegion;
  logic [23:0] dbAddr;
  logic dbWrite;
  logic [1:0] dbWidth;
  logic [31:0] dbWdata;
  logic [31:0] dbRdata;
  logic fbValid;
  logic [2:0] fbRegion;
  logic [23:0] fbAddr;
  logic [15:0] fbRdata;
  int nFail = 0;
  int totalChecks = 0;
  logic [31:0] r;
  logic e;

  // 125 MHz system clock
  always #4 clock = ~clock;

  memory_map_bus_access #(.ID_CODE(ID)) memory_map_bus_access_inst (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dataValid(dataValid), .dataAddr(dataAddr), .dataSize(dataSize), .dataWrite(dataWrite),
    .dataWdata(dataWdata), .dataStack(dataStack), .dataAccept(dataAccept),
    .dataDone(dataDone), .dataRdata(dataRdata), .fetchValid(fetchValid),
    .fetchAddr(fetchAddr), .fetchReady(fetchReady), .fetchDone(fetchDone),
    .fetchRdata(fetchRdata), .dbValid(dbValid), .dbRegion(dbRegion), .dbAddr(dbAddr),
    .dbWrite(dbWrite), .dbWidth(dbWidth), .dbWdata(dbWdata), .dbRdata(dbRdata),
    .fbValid(fbValid), .fbRegion(fbRegion), .fbAddr(fbAddr), .fbRdata(fbRdata)
  );

  mem_side_model mem_side_model_inst (
    .clock(clock), .dbValid(dbValid), .dbWrite(dbWrite), .dbAddr(dbAddr),
    .dbRdata(dbRdata), .fbValid(fbValid), .fbAddr(fbAddr), .fbRdata(fbRdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic endSim();
    if (nFail == 0 && totalChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    totalChecks++;
    if (s !== x) begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
      nFail++;
    end
  endtask

  // one apb transfer; the request stands until pready is sampled high
  task automatic apb(input logic wr, input logic [23:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      nFail++;
      endSim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one cpu data access; counts lanes, cycles to done and fetch stall cycles
  task automatic dat(input logic [23:0] a, input logic [1:0] sz, input logic wr,
                     input logic stk, input logic [31:0] wd, input logic [31:0] ev,
                     input int n, input int ln, input int st,
                     input logic [2:0] rg, input logic [1:0] w);
    int k;
    int c;
    int s;
    k = 0;
    c = 0;
    s = 0;
    @(posedge clock);
    dataValid <= 1'b1;
    dataAddr <= a;
    dataSize <= sz;
    dataWrite <= wr;
    dataStack <= stk;
    dataWdata <= wd;
    @(posedge clock);
    chk(dataAccept, 1'b1);
    dataValid <= 1'b0;
    while (c < 20) begin
      @(posedge clock);
      c++;
      if (fetchValid && fetchReady !== 1'b1) s++;
      if (dbValid === 1'b1) begin
        chk(dbAddr, a + k * (1 << w)); // lane address
        chk(dbRegion, rg);
        chk(dbWidth, w); // device width
        chk(dbWrite, wr);
        if (wr && k == 0) chk(dbWdata, ev);
        k++;
      end
      if (dataDone === 1'b1) break;
    end
    if (c == 20) begin
      nFail++;
      endSim();
    end
    chk(c, n + 1);
    if (!wr) chk(dataRdata, ev);
    if (ln >= 0) chk(k, ln);
    chk(s, st);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic scApb();
    apb(1'b0, `ID_ADDR, 32'h0, r, e);
    chk(r, {24'h0, ID}); // identity
    apb(1'b1, `ID_ADDR, 32'hFFFFFFFF, r, e);
    apb(1'b0, `ID_ADDR, 32'h0, r, e);
    chk(r, {24'h0, ID}); // write ignored
    apb(1'b0, 24'hFFFF90, 32'h0, r, e);
    chk(r, 32'h0); // unmapped
    chk({31'h0, e}, 32'h1); // unmapped
    // fenced debug ram behaves as reserved
    apb(1'b1, `CTRL_ADDR, 32'h1, r, e);
    apb(1'b0, `CTRL_ADDR, 32'h0, r, e);
    chk(r, 32'h1);
    dat(24'h0007C0, 2'h2, 1'b0, 1'b0, 32'h0, 32'h0, 1, 0, 0, 3'h2, 2'h2);
    apb(1'b1, `CTRL_ADDR, 32'h0, r, e);
  endtask

  task automatic scSplit();
    dat(24'h004104, 2'h0, 1'b0, 1'b0, 32'h0, 32'h04, 1, 1, 0, 3'h3, 2'h0);
    dat(24'h004104, 2'h1, 1'b0, 1'b0, 32'h0, 32'h0504, 2, 2, 0, 3'h3, 2'h0);
    dat(24'h004104, 2'h2, 1'b0, 1'b0, 32'h0, 32'h00060504, 4, 4, 0, 3'h3, 2'h0);
    dat(24'h004300, 2'h1, 1'b0, 1'b0, 32'h0, 32'h4300, 1, 1, 0, 3'h3, 2'h1);
    dat(24'h004300, 2'h2, 1'b0, 1'b0, 32'h0, 32'h00024300, 2, 2, 0, 3'h3, 2'h1);
    dat(24'h005000, 2'h1, 1'b0, 1'b0, 32'h0, 32'h0100, 2, 2, 0, 3'h4, 2'h0);
    dat(24'h005400, 2'h2, 1'b0, 1'b0, 32'h0, 32'h00025400, 2, 2, 0, 3'h4, 2'h1);
    dat(24'h000100, 2'h0, 1'b0, 1'b0, 32'h0, 32'h00, 1, 1, 0, 3'h1, 2'h2);
    dat(24'h000100, 2'h1, 1'b0, 1'b0, 32'h0, 32'h0100, 1, 1, 0, 3'h1, 2'h2);
    dat(24'h000100, 2'h2, 1'b0, 1'b0, 32'h0, 32'h100, 1, 1, 0, 3'h1, 2'h2);
    dat(24'h000100, 2'h2, 1'b0, 1'b1, 32'h0, 32'hC3000100, 1, 1, 0, 3'h1, 2'h2);
    dat(24'h000100, 2'h2, 1'b1, 1'b0, 32'hDEADBEEF, 32'h00ADBEEF, 1, 1, 0, 3'h1, 2'h2);
    dat(24'h000100, 2'h2, 1'b1, 1'b1, 32'hDEADBEEF, 32'hDEADBEEF, 1, 1, 0, 3'h1, 2'h2);
    dat(`ID_ADDR, 2'h0, 1'b0, 1'b0, 32'h0, {24'h0, ID}, 1, 0, 0, 3'h7, 2'h2);
    dat(24'h006000, 2'h2, 1'b0, 1'b0, 32'h0, 32'h0, 1, -1, 0, 3'h0, 2'h2);
  endtask

  task automatic scFetch();
    @(posedge clock);
    fetchValid <= 1'b1;
    fetchAddr <= 24'h008000;
    @(posedge clock);
    chk(fetchReady, 1'b1); // no conflict
    chk(fbValid, 1'b1);
    chk(fbRegion, 3'h5);
    chk(fbAddr, 24'h008000);
    @(posedge clock);
    chk({fetchDone, fetchRdata}, 17'h1D555);
    dat(24'h008000, 2'h2, 1'b0, 1'b0, 32'h0, 32'h00028000, 2, 2, 2, 3'h5, 2'h1);
    dat(24'h000100, 2'h2, 1'b0, 1'b0, 32'h0, 32'h100, 1, 1, 0, 3'h1, 2'h2);
    dat(24'h00FFFC, 2'h1, 1'b0, 1'b0, 32'h0, 32'hFFFC, 1, 1, 1, 3'h6, 2'h1);
    fetchAddr <= 24'h000200;
    dat(24'h0007C0, 2'h2, 1'b0, 1'b0, 32'h0, 32'h7C0, 1, 1, 1, 3'h2, 2'h2);
    dat(24'h004300, 2'h2, 1'b0, 1'b0, 32'h0, 32'h00024300, 2, 2, 0, 3'h3, 2'h1);
    fetchValid <= 1'b0;
    // status: four stalled fetch cycles, last region peripheral area 1, idle
    apb(1'b0, `STAT_ADDR, 32'h0, r, e);
    chk(r, 32'h00040006);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // reset held for eight cycles, then the scenarios in turn
  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    scApb();
    scSplit();
    scFetch();
    repeat (2) @(posedge clock);
    endSim();
  end
endmodule

`default_nettype wire
